// File: spc_asserts.sv
// concurrent checks on the sleep controller ports
`timescale 1ns/1ps
module spc_asserts #(
    parameter int NPER = spc_pkg::SPC_NPER
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sleep_en,
    input wire logic [2:0] sleep_mode,
    input wire logic sleep_instr,
    input wire spc_pkg::spc_wake_t irq_pend,
    input wire logic nvm_busy,
    input wire logic [NPER-1:0] per_gate,
    input wire logic cpu_stall,
    input wire spc_pkg::spc_clken_t clk_en,
    input wire logic [NPER-1:0] per_clk_en,
    input wire logic asleep,
    input wire logic wake_pulse
);
    import spc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [2:0] mode_r;
    logic legal;
    logic take;
    logic pd;
    logic pd_src;
    logic idl;
    assign legal = sleep_mode inside {SPC_SMODE_IDLE, SPC_SMODE_PDOWN, SPC_SMODE_PSAVE,
        SPC_SMODE_STDBY, SPC_SMODE_ESTDBY};
    // legal modes only, so a refused request never looks taken
    assign take = sleep_instr && sleep_en && legal && !cpu_stall && !asleep;
    assign pd = asleep && mode_r == SPC_SMODE_PDOWN;
    assign pd_src = irq_pend.twi_addr || irq_pend.port_async || irq_pend.usb_resume;
    assign idl = asleep && mode_r == SPC_SMODE_IDLE;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) mode_r <= SPC_SMODE_IDLE;
        else if (take) mode_r <= sleep_mode;
    end
    // a wake source already pending at entry skips asleep and shows as wake_pulse
    sequence s_enter;
        cpu_stall ##1 (asleep || wake_pulse);
    endsequence
    sequence s_hold;
        cpu_stall [*4] ##1 !cpu_stall;
    endsequence
    chk_sleep_taken: assert property (take |=> s_enter) else $error("sleep not entered");
    chk_sleep_refused: assert property (sleep_instr && !(sleep_en && legal) && !cpu_stall && !asleep
        |=> !cpu_stall) else $error("refused sleep stalled");
    chk_wake_hold: assert property (wake_pulse |-> s_hold) else $error("wake hold length");
    chk_wake_clocks: assert property (wake_pulse |-> clk_en == SPC_CLK_ALL) else $error("clocks off at wake");
    chk_idle_clocks: assert property (idl |-> !clk_en.cpu && clk_en.per && clk_en.nvm == $past(nvm_busy))
        else $error("idle clocks");
    chk_idle_wake: assert property (idl && |irq_pend |=> wake_pulse) else $error("idle no wake");
    chk_pdown_clocks: assert property (pd |-> clk_en == '0) else $error("power-down clock runs");
    chk_pdown_ignore: assert property (pd && !pd_src |=> !wake_pulse) else $error("power-down woke");
    chk_gate_follow: assert property (!$past(sys_rst)
        && (!asleep && !$past(asleep) || idl && $past(asleep))
        |-> per_clk_en == ~$past(per_gate)) else $error("gate not followed");
endmodule // spc_asserts

// File: spc_core_model.sv
// core and interrupt controller model facing the sleep controller
`timescale 1ns/1ps
module spc_core_model (
    input wire logic mclk,
    input wire logic cpu_stall,
    input wire logic go,
    input wire spc_pkg::spc_wake_t irq_req,
    output logic sleep_instr,
    output spc_pkg::spc_wake_t irq_pend
);
    import spc_pkg::*;
    initial sleep_instr = 1'b0;
    initial irq_pend = '0;
    // sleep only while running, one cycle wide
    // pending classes only; handler order and return point stay in the core
    always @(negedge mclk) begin
        sleep_instr <= go && !cpu_stall && !sleep_instr;
        irq_pend <= irq_req;
    end
endmodule // spc_core_model

// File: spc_pkg.sv
// package for the sleep power controller: modes, widths, wake source layout, timing
package spc_pkg;
    // sleep mode select encoding (3 bits)
    localparam logic [2:0] SPC_SMODE_IDLE = 3'h0;
    localparam logic [2:0] SPC_SMODE_PDOWN = 3'h2;
    localparam logic [2:0] SPC_SMODE_PSAVE = 3'h3;
    localparam logic [2:0] SPC_SMODE_STDBY = 3'h6;
    localparam logic [2:0] SPC_SMODE_ESTDBY = 3'h7;
    localparam int SPC_WAKE_HOLD = 4;
    localparam logic [2:0] SPC_HOLD_LAST = 3'h3;
    localparam logic [2:0] SPC_HOLD_ZERO = 3'h0;
    localparam int SPC_NPER = 16;
    localparam logic [SPC_NPER-1:0] SPC_GATE_RST = 16'h0000;

    typedef enum logic [1:0] {
        SPC_ST_ACTIVE,
        SPC_ST_SLEEP,
        SPC_ST_HOLD
    } spc_state_t;

    // clock enables driven to the clock tree
    typedef struct packed {
        logic cpu;
        logic nvm;
        logic per;
        logic rtc;
        logic osc;
    } spc_clken_t;

    // classes of pending interrupt that may wake the device
    typedef struct packed {
        logic twi_addr;
        logic port_async;
        logic usb_resume;
        logic rtc;
        logic other;
    } spc_wake_t;

    localparam spc_clken_t SPC_CLK_ALL = '{cpu: 1'b1, nvm: 1'b1, per: 1'b1, rtc: 1'b1, osc: 1'b1};
endpackage

// File: spc_sleep_ctrl.sv
// sleep mode and peripheral clock gating controller
// Contract
// R1: five sleep modes, entered only from active by the sleep instruction
// R2: wake by interrupt runs its handler then continues after sleep instruction
// R3: higher priority pending interrupts are served first, in priority order
// R4: after any wake-up the core stays stalled for four cycles
// R5: register file, sram and registers keep their contents while asleep
// R6: reset during sleep gives full reset, execution from reset vector
// R7: idle stops cpu and nvm clocks, nvm programming finishes, peripherals run
// R8: in idle any enabled interrupt wakes the device
// R9: power-down stops every clock including the real-time counter source
// R10: power-down wakes only on twi address, async port, usb resume
// R11: wake sources depend on mode; enabled resets always wake
// R12: per-peripheral gates stop each clock, freezing its state
// R13: per-peripheral gating acts in active and idle modes
// R14: mode encoding and unspecified mode clock behaviour chosen here
`timescale 1ns/1ps
module spc_sleep_ctrl #(
    parameter int NPER = spc_pkg::SPC_NPER
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sleep_en,
    input wire logic [2:0] sleep_mode,
    input wire logic sleep_instr,
    input wire spc_pkg::spc_wake_t irq_pend,
    input wire logic nvm_busy,
    input wire logic [NPER-1:0] per_gate,
    output logic cpu_stall,
    output spc_pkg::spc_clken_t clk_en,
    output logic [NPER-1:0] per_clk_en,
    output logic asleep,
    output logic wake_pulse
);
    import spc_pkg::*;

    spc_state_t state_r;
    logic [2:0] mode_r;
    logic [2:0] hold_r;
    logic wake;
    logic enter;
    logic hold_done;
    logic dozing;

    // mode legality: only the five coded modes are accepted
    function automatic logic mode_ok(input logic [2:0] m);
        mode_ok = (m == SPC_SMODE_IDLE) || (m == SPC_SMODE_PDOWN) || (m == SPC_SMODE_PSAVE) ||
                  (m == SPC_SMODE_STDBY) || (m == SPC_SMODE_ESTDBY);
    endfunction

    // request taken this cycle: only from active, refused when disabled or illegal [R1]
    assign enter = (state_r == SPC_ST_ACTIVE) && sleep_en && sleep_instr && mode_ok(sleep_mode);

    // last of the four stall cycles after a wake-up [R4]
    assign hold_done = (state_r == SPC_ST_HOLD) && (hold_r == SPC_HOLD_LAST);

    // asleep with no accepted wake source; clocks are cut only here
    assign dozing = (state_r == SPC_ST_SLEEP) && !wake;

    spc_wake_filter u_wake (
        .mode(mode_r),
        .pend(irq_pend),
        .wake(wake)
    );

    // reset is asynchronous so a reset while asleep returns straight to active, from the vector [R6] [R11]
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= SPC_ST_ACTIVE;
        end else begin
            unique case (state_r)
                SPC_ST_ACTIVE: begin
                    if (enter) begin
                        state_r <= SPC_ST_SLEEP; // [R1]
                    end
                end
                SPC_ST_SLEEP: begin
                    if (wake) begin
                        state_r <= SPC_ST_HOLD; // [R8] [R10]
                    end
                end
                SPC_ST_HOLD: begin
                    if (hold_done) begin
                        state_r <= SPC_ST_ACTIVE; // [R4]
                    end
                end
                // the unused fourth code falls back to active rather than locking the core
                default: begin
                    state_r <= SPC_ST_ACTIVE;
                end
            endcase
        end
    end

    // mode latched at entry; later writes cannot change an ongoing sleep
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= SPC_SMODE_IDLE;
        end else if (enter) begin
            mode_r <= sleep_mode; // [R14]
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_r <= SPC_HOLD_ZERO;
        end else if (state_r == SPC_ST_HOLD) begin
            hold_r <= hold_r + 3'h1; // [R4]
        end else begin
            hold_r <= SPC_HOLD_ZERO;
        end
    end

    // stall only, no pc change: the core resumes after the sleep instruction and
    // then takes pending interrupts through the controller in priority order [R2] [R3]
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_stall <= 1'b0;
        end else if (enter) begin
            cpu_stall <= 1'b1; // [R1]
        end else if (state_r == SPC_ST_ACTIVE || hold_done) begin
            cpu_stall <= 1'b0; // [R4]
        end else begin
            cpu_stall <= 1'b1; // [R4]
        end
    end

    // drops in the cycle the wake is taken, so it never overlaps wake_pulse
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            asleep <= 1'b0;
        end else begin
            asleep <= dozing;
        end
    end

    // one cycle wide: sleep is left at the first accepted wake
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= (state_r == SPC_ST_SLEEP) && wake; // [R11]
        end
    end

    // clock enables; gating never resets anything, so all state is retained [R5]
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_en <= SPC_CLK_ALL;
        end else if (dozing) begin
            clk_en.cpu <= 1'b0; // [R7]
            unique case (mode_r)
                SPC_SMODE_IDLE: begin
                    clk_en.nvm <= nvm_busy; // [R7]
                    clk_en.per <= 1'b1; // [R7]
                    clk_en.rtc <= 1'b1;
                    clk_en.osc <= 1'b1;
                end
                SPC_SMODE_PSAVE: begin
                    clk_en.nvm <= nvm_busy; // [R14]
                    clk_en.per <= 1'b0; // [R14]
                    clk_en.rtc <= 1'b1;
                    clk_en.osc <= 1'b0;
                end
                SPC_SMODE_STDBY: begin
                    clk_en.nvm <= nvm_busy; // [R14]
                    clk_en.per <= 1'b0; // [R14]
                    clk_en.rtc <= 1'b0;
                    clk_en.osc <= 1'b1;
                end
                SPC_SMODE_ESTDBY: begin
                    clk_en.nvm <= nvm_busy; // [R14]
                    clk_en.per <= 1'b0; // [R14]
                    clk_en.rtc <= 1'b1;
                    clk_en.osc <= 1'b1;
                end
                // power-down stops nvm even mid-programming: software waits for nvm idle first
                default: begin
                    clk_en.nvm <= 1'b0; // [R9]
                    clk_en.per <= 1'b0; // [R9]
                    clk_en.rtc <= 1'b0;
                    clk_en.osc <= 1'b0;
                end
            endcase
        end else begin
            clk_en <= SPC_CLK_ALL;
        end
    end

    // peripheral gates apply whenever the peripheral clock itself runs [R12] [R13]
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            per_clk_en <= ~SPC_GATE_RST[NPER-1:0];
        end else if (dozing && mode_r != SPC_SMODE_IDLE) begin
            per_clk_en <= '0;
        end else begin
            per_clk_en <= ~per_gate; // [R12] [R13]
        end
    end
endmodule // spc_sleep_ctrl

// File: spc_wake_filter.sv
// wake source qualification per sleep mode
`timescale 1ns/1ps
module spc_wake_filter (
    input wire logic [2:0] mode,
    input wire spc_pkg::spc_wake_t pend,
    output logic wake
);
    import spc_pkg::*;
    always_comb begin
        unique case (mode)
            SPC_SMODE_IDLE: wake = |pend; // [R8] [R11]
            SPC_SMODE_PDOWN: wake = pend.twi_addr | pend.port_async | pend.usb_resume; // [R10] [R11]
            SPC_SMODE_PSAVE, SPC_SMODE_ESTDBY: wake = pend.twi_addr | pend.port_async | pend.usb_resume | pend.rtc; // [R14]
            SPC_SMODE_STDBY: wake = pend.twi_addr | pend.port_async | pend.usb_resume; // [R14]
            default: wake = 1'b0;
        endcase
    end
endmodule // spc_wake_filter

// File: test_spc_sleep_ctrl.sv
// self-checking bench for the sleep power controller
`timescale 1ns/1ps
module test_spc_sleep_ctrl;
    import spc_pkg::*;
    typedef struct packed {logic [2:0] m; logic [4:0] bad; logic [4:0] good; logic [4:0] clk;} spc_row_t;
    localparam spc_row_t ROWS [5] = '{'{3'h0, 5'h00, 5'h01, 5'h07}, '{3'h2, 5'h03, 5'h10, 5'h00},
        '{3'h3, 5'h01, 5'h02, 5'h02}, '{3'h6, 5'h03, 5'h08, 5'h01}, '{3'h7, 5'h01, 5'h04, 5'h03}};
    logic mclk = 0, sys_rst = 1, sleep_en = 1, go = 0, nvm_busy = 0, sleep_instr, cpu_stall, asleep, wake_pulse;
    logic [2:0] sleep_mode = 3'h0;
    logic [15:0] per_gate = 16'h0000, per_clk_en;
    spc_wake_t irq_req = '0, irq_pend;
    spc_clken_t clk_en;
    int err_count = 0, total_checks = 0;
    spc_sleep_ctrl i_spc_sleep_ctrl (.mclk(mclk), .sys_rst(sys_rst), .sleep_en(sleep_en), .sleep_mode(sleep_mode),
        .sleep_instr(sleep_instr), .irq_pend(irq_pend), .nvm_busy(nvm_busy), .per_gate(per_gate),
        .cpu_stall(cpu_stall), .clk_en(clk_en), .per_clk_en(per_clk_en), .asleep(asleep), .wake_pulse(wake_pulse));
    spc_core_model i_spc_core_model (.mclk(mclk), .cpu_stall(cpu_stall), .go(go), .irq_req(irq_req),
        .sleep_instr(sleep_instr), .irq_pend(irq_pend));
    always #25 mclk = ~mclk;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // bounded wait: a refused request simply runs the count out
    task automatic nap(input logic [2:0] m);
        sleep_mode <= m;
        go <= 1'b1;
        @(negedge mclk);
        go <= 1'b0;
        for (int i = 0; i < 8 && asleep !== 1'b1; i++) @(negedge mclk);
    endtask
    initial begin
        #200000;
        err_count++;
        give_verdict;
    end
    initial begin
        repeat (5) @(negedge mclk);
        sys_rst <= 1'b0;
        per_gate <= 16'h00f0;
        foreach (ROWS[k]) begin
            nap(ROWS[k].m);
            chk("clk_en", ROWS[k].clk, clk_en);
            chk("per_clk_en", ROWS[k].m == SPC_SMODE_IDLE ? 16'hff0f : 16'h0000, per_clk_en);
            irq_req <= ROWS[k].bad;
            repeat (4) @(negedge mclk);
            chk("asleep", 1, asleep);
            irq_req <= ROWS[k].good;
            for (int i = 0; i < 20 && (i < 2 || cpu_stall !== 1'b0); i++) @(negedge mclk);
            irq_req <= '0;
            chk("woken", {1'b0, SPC_CLK_ALL}, {asleep, clk_en});
            chk("per_clk_en", 16'hff0f, per_clk_en);
        end
        nvm_busy <= 1'b1;
        nap(SPC_SMODE_IDLE);
        chk("clk_en nvm", 16'h000f, clk_en);
        irq_req <= 5'h10;
        repeat (8) @(negedge mclk);
        irq_req <= '0;
        chk("cpu_stall", 16'h0000, cpu_stall);
        sleep_en <= 1'b0;
        nap(SPC_SMODE_IDLE);
        chk("cpu_stall", 0, cpu_stall);
        sleep_en <= 1'b1;
        nap(3'h1);
        chk("cpu_stall", 0, cpu_stall);
        nap(SPC_SMODE_PDOWN);
        chk("clk_en pdown", 16'h0000, clk_en);
        sys_rst <= 1'b1;
        @(negedge mclk);
        sys_rst <= 1'b0;
        chk("reset", {3'h0, SPC_CLK_ALL}, {asleep, cpu_stall, wake_pulse, clk_en});
        nvm_busy <= 1'b0;
        nap(SPC_SMODE_IDLE);
        chk("asleep", 16'h0001, asleep);
        give_verdict;
    end
endmodule // test_spc_sleep_ctrl
bind spc_sleep_ctrl spc_asserts #(.NPER(NPER)) i_spc_asserts (.mclk(mclk), .sys_rst(sys_rst), .sleep_en(sleep_en),
    .sleep_mode(sleep_mode), .sleep_instr(sleep_instr), .irq_pend(irq_pend), .nvm_busy(nvm_busy),
    .per_gate(per_gate), .cpu_stall(cpu_stall), .clk_en(clk_en), .per_clk_en(per_clk_en), .asleep(asleep),
    .wake_pulse(wake_pulse));
